/* File: rtl/rfe_regs.vh */
// Operation
// - Message already issued leaves before any register read completes.
// - Primary mode: no fault event while primary_pending is set.
// - primary_pending is the OR of all record fault-valid bits.
// - Primary mode: interrupt_pending sets when a fault is recorded with none pending.
// - Primary: pending with mask clear sends message and clears pending; mask set holds.
// - Primary: clearing interrupt_mask while pending sends message and clears pending.
// - Primary: pending cleared silently once software leaves all fault-valid bits clear.
// - Advanced mode: pending taken from advanced_pending; no event while it is set.
// - Advanced: interrupt_pending sets only for index 0 record with nothing pending.
// - Advanced: pending with mask clear sends message and clears pending.
// - Advanced: clearing interrupt_mask while pending sends message and clears pending.
// - Advanced: software clearing advanced_pending clears interrupt_pending without message.
// - Data register: payload 15:0; 31:16 only with 32-bit data, else zero.
// - Low address register holds bits 31:2; bits 1:0 read zero.
// - High address register holds upper 32 bits, else reads zero.
// - Record fault-valid bit 127 sets only after its fields are written.
// - Fault-valid is write-one-to-clear; records sticky, cleared only by power-good reset.
// - Faults from a requester already held in a valid record are merged.
// - Type bit 126: 0 for faulted write, 1 for faulted read.
// - Record holds reason in 103:96 and requester identifier in 79:64.
// - Record holds page address 63:12; bits above guest width read zero.
// - Records are 128-bit aligned, read as four doublewords, valid bit highest.
// - interrupt_mask, control bit 31, resets to one.
// - interrupt_pending, control bit 30, is read-only and set by hardware.
`ifndef RFE_REGS_VH
`define RFE_REGS_VH

`define RFE_ADDR_W        12
`define RFE_OFF_STATUS    12'h034
`define RFE_OFF_CONTROL   12'h038
`define RFE_OFF_DATA      12'h03C
`define RFE_OFF_ADDR_LO   12'h040
`define RFE_OFF_ADDR_HI   12'h044
`define RFE_OFF_ADV_LOG   12'h058
`define RFE_REC_PAGE      4'h1
`define RFE_REC_DW_HI     2'h3

`define RFE_STS_PFO       0
`define RFE_STS_PPF       1
`define RFE_STS_FRI_LO    8
`define RFE_CTL_IP        30
`define RFE_CTL_IM        31
`define RFE_ADV_APF       1
`define RFE_REC_F         127
`define RFE_REC_TYPE      126
`define RFE_DW_F          31
`define RFE_DW_TYPE       30

`define RFE_IM_RESET      1'h1
`define RFE_ZERO32        32'h0000_0000

`endif

/* File: rtl/rfe_record_slot.v */
`timescale 1ns/1ps
`include "rfe_regs.vh"

// One sticky 128-bit fault record
module rfe_record_slot #(
    parameter MAX_GUEST_ADDR_WIDTH = 48
) (
    input  wire         mclk_in,
    input  wire         pg_rst_n_in,
    input  wire         load_in,
    input  wire         set_valid_in,
    input  wire         clear_in,
    input  wire [51:0]  page_in,
    input  wire [15:0]  sid_in,
    input  wire [7:0]   reason_in,
    input  wire         is_read_in,
    output wire         valid_out,
    output wire [15:0]  sid_out,
    output wire [127:0] record_out
);
    localparam [63:0] ADDR_MASK = (MAX_GUEST_ADDR_WIDTH >= 64) ? {64{1'b1}} : ((64'h1 << MAX_GUEST_ADDR_WIDTH) - 64'h1);

    reg        valid_ff;
    reg        type_ff;
    reg [7:0]  reason_ff;
    reg [15:0] sid_ff;
    reg [51:0] page_ff;

    wire [63:0] page_masked = {page_ff, 12'h000} & ADDR_MASK;

    always @(posedge mclk_in or negedge pg_rst_n_in) begin
        if (!pg_rst_n_in) begin
            valid_ff  <= 1'b0;
            type_ff   <= 1'b0;
            reason_ff <= 8'h00;
            sid_ff    <= 16'h0000;
            page_ff   <= 52'h0;
        end else begin
            if (load_in) begin
                type_ff   <= is_read_in;
                reason_ff <= reason_in;
                sid_ff    <= sid_in;
                page_ff   <= page_in;
            end
            // Hardware set beats a software clear in the same cycle
            if (set_valid_in)
                valid_ff <= 1'b1;
            else if (clear_in)
                valid_ff <= 1'b0;
        end
    end

    assign valid_out  = valid_ff;
    assign sid_out    = sid_ff;
    assign record_out = {valid_ff, type_ff, 22'h0, reason_ff, 16'h0000, sid_ff,
                         page_masked[63:12], 12'h000};

endmodule // rfe_record_slot

/* File: rtl/rfe_fault_event.v */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "rfe_regs.vh"

// Fault recording and fault event message generation
module rfe_fault_event #(
    parameter NUM_REC    = 4,
    parameter IDX_W      = 2,
    parameter MAX_GUEST_ADDR_WIDTH       = 48,
    parameter MSG_DATA32 = 1,
    parameter MSG_ADDR64 = 1
) (
    input  wire                   mclk_in,
    input  wire                   resetn_in,
    input  wire                   pwrgood_resetn_in,
    input  wire [`RFE_ADDR_W-1:0] reg_addr_in,
    input  wire [31:0]            reg_wdata_in,
    input  wire                   reg_wr_in,
    input  wire                   reg_rd_in,
    output reg  [31:0]            reg_rdata_out,
    input  wire                   adv_mode_in,
    input  wire                   fault_in,
    input  wire [51:0]            fault_page_in,
    input  wire [15:0]            fault_sid_in,
    input  wire [7:0]             fault_reason_in,
    input  wire                   fault_is_read_in,
    input  wire                   adv_rec_in,
    input  wire                   adv_rec_idx_zero_in,
    output wire                   primary_pending_out,
    output wire                   msg_valid_out,
    output wire [63:0]            msg_addr_out,
    output wire [31:0]            msg_data_out
);
    // Reset release through two flops, one chain per reset
    reg  [1:0] rst_sync_ff;
    reg  [1:0] pg_sync_ff;
    wire       rst_n    = rst_sync_ff[1];
    wire       pg_rst_n = pg_sync_ff[1];

    always @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in)
            rst_sync_ff <= 2'h0;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end

    // Power-good chain ignores the ordinary reset pin and follows only its own pin
    always @(posedge mclk_in or negedge pwrgood_resetn_in) begin
        if (!pwrgood_resetn_in)
            pg_sync_ff <= 2'h0;
        else
            pg_sync_ff <= {pg_sync_ff[0], 1'b1};
    end

    // Register decode
    wire                 wr_sts  = reg_wr_in && (reg_addr_in == `RFE_OFF_STATUS);
    wire                 wr_ctl  = reg_wr_in && (reg_addr_in == `RFE_OFF_CONTROL);
    wire                 wr_data = reg_wr_in && (reg_addr_in == `RFE_OFF_DATA);
    wire                 wr_alo  = reg_wr_in && (reg_addr_in == `RFE_OFF_ADDR_LO);
    wire                 wr_ahi  = reg_wr_in && (reg_addr_in == `RFE_OFF_ADDR_HI);
    wire                 wr_adv  = reg_wr_in && (reg_addr_in == `RFE_OFF_ADV_LOG);
    wire [3:0]           acc_slot = reg_addr_in[7:4];
    wire [1:0]           acc_dw   = reg_addr_in[3:2];
    wire                 acc_rec  = (reg_addr_in[11:8] == `RFE_REC_PAGE) &&
                                    (reg_addr_in[1:0] == 2'h0) &&
                                    ({28'h0, acc_slot} < NUM_REC);

    // Event and message state
    reg                  im_ff;
    reg                  ip_ff;
    reg                  apf_ff;
    reg                  pfo_ff;
    reg [IDX_W-1:0]      fri_ff;
    reg [IDX_W-1:0]      wr_idx_ff;
    reg                  rec_pend_ff;
    reg                  rec_first_ff;
    reg [IDX_W-1:0]      rec_idx_ff;
    reg [31:0]           data_ff;
    reg [31:2]           alo_ff;
    reg [31:0]           ahi_ff;
    reg                  msg_valid_ff;
    reg [63:0]           msg_addr_ff;
    reg [31:0]           msg_data_ff;

    // Record array
    wire [NUM_REC-1:0]   valid_vec;
    wire [NUM_REC-1:0]   sid_hit;
    wire [NUM_REC-1:0]   load_vec;
    wire [NUM_REC-1:0]   setv_vec;
    wire [NUM_REC-1:0]   clr_vec;
    wire [127:0]         rec_word [0:NUM_REC-1];
    wire [15:0]          rec_sid  [0:NUM_REC-1];

    wire primary_pending       = |valid_vec;
    wire merged    = |sid_hit;
    wire slot_busy = valid_vec[wr_idx_ff];
    wire prim_rec  = fault_in && !adv_mode_in;
    wire do_load   = prim_rec && !merged && !slot_busy;
    wire do_ovf    = prim_rec && !merged && slot_busy;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REC; gi = gi + 1) begin : g_rec
            assign sid_hit[gi]  = valid_vec[gi] && (rec_sid[gi] == fault_sid_in);
            assign load_vec[gi] = do_load && (wr_idx_ff == gi);
            assign setv_vec[gi] = rec_pend_ff && (rec_idx_ff == gi);
            // Fault-valid clears when a one lands on bit 31 of the top doubleword
            assign clr_vec[gi]  = reg_wr_in && acc_rec && (acc_slot == gi) &&
                                  (acc_dw == `RFE_REC_DW_HI) &&
                                  reg_wdata_in[`RFE_DW_F];

            rfe_record_slot #(
                .MAX_GUEST_ADDR_WIDTH (MAX_GUEST_ADDR_WIDTH)
            ) u_slot (
                .mclk_in      (mclk_in),
                .pg_rst_n_in  (pg_rst_n),
                .load_in      (load_vec[gi]),
                .set_valid_in (setv_vec[gi]),
                .clear_in     (clr_vec[gi]),
                .page_in      (fault_page_in),
                .sid_in       (fault_sid_in),
                .reason_in    (fault_reason_in),
                .is_read_in   (fault_is_read_in),
                .valid_out    (valid_vec[gi]),
                .sid_out      (rec_sid[gi]),
                .record_out   (rec_word[gi])
            );
        end
    endgenerate

    // Recording index and in-flight record, valid bit follows one cycle after the fields
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            wr_idx_ff    <= {IDX_W{1'b0}};
            rec_pend_ff  <= 1'b0;
            rec_first_ff <= 1'b0;
            rec_idx_ff   <= {IDX_W{1'b0}};
        end else begin
            rec_pend_ff <= do_load;
            if (do_load) begin
                rec_idx_ff   <= wr_idx_ff;
                rec_first_ff <= !primary_pending && !rec_pend_ff;
                wr_idx_ff    <= (wr_idx_ff == NUM_REC - 1) ? {IDX_W{1'b0}} :
                                wr_idx_ff + {{(IDX_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Event conditions
    wire prim_set  = !adv_mode_in && rec_pend_ff && rec_first_ff;
    wire adv_hit   = adv_mode_in && adv_rec_in && adv_rec_idx_zero_in;
    wire adv_set   = adv_hit && !apf_ff;
    wire apf_clr   = wr_adv && reg_wdata_in[`RFE_ADV_APF];
    wire prim_quiet = !adv_mode_in && ip_ff && !primary_pending && !rec_pend_ff;
    wire adv_quiet = adv_mode_in && ip_ff && apf_ff && apf_clr;
    wire ip_set    = prim_set || adv_set;
    wire quiet     = prim_quiet || adv_quiet;
    // Mask clear, either held or just written, releases the message
    wire send      = ip_ff && !im_ff && !quiet;

    // Sticky status: first index, overflow, advanced pending
    always @(posedge mclk_in or negedge pg_rst_n) begin
        if (!pg_rst_n) begin
            fri_ff <= {IDX_W{1'b0}};
            pfo_ff <= 1'b0;
            apf_ff <= 1'b0;
        end else begin
            if (prim_set)
                fri_ff <= rec_idx_ff;
            if (do_ovf)
                pfo_ff <= 1'b1;
            else if (wr_sts && reg_wdata_in[`RFE_STS_PFO])
                pfo_ff <= 1'b0;
            if (adv_set)
                apf_ff <= 1'b1;
            else if (apf_clr)
                apf_ff <= 1'b0;
        end
    end

    // Control and message registers
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            im_ff   <= `RFE_IM_RESET;
            ip_ff   <= 1'b0;
            data_ff <= `RFE_ZERO32;
            alo_ff  <= 30'h0;
            ahi_ff  <= `RFE_ZERO32;
        end else begin
            if (wr_ctl)
                im_ff <= reg_wdata_in[`RFE_CTL_IM];
            // Hardware set beats any clear in the same cycle
            if (ip_set)
                ip_ff <= 1'b1;
            else if (send || quiet)
                ip_ff <= 1'b0;
            if (wr_data) begin
                data_ff[15:0] <= reg_wdata_in[15:0];
                if (MSG_DATA32 != 0)
                    data_ff[31:16] <= reg_wdata_in[31:16];
            end
            if (wr_alo)
                alo_ff <= reg_wdata_in[31:2];
            if (wr_ahi && (MSG_ADDR64 != 0))
                ahi_ff <= reg_wdata_in;
        end
    end

    // One posted write per event, a single-cycle pulse that cannot be held back
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            msg_valid_ff <= 1'b0;
            msg_addr_ff  <= 64'h0;
            msg_data_ff  <= `RFE_ZERO32;
        end else begin
            msg_valid_ff <= send;
            if (send) begin
                msg_addr_ff <= {ahi_ff, alo_ff, 2'h0};
                msg_data_ff <= data_ff;
            end
        end
    end

    assign msg_valid_out       = msg_valid_ff;
    assign msg_addr_out        = msg_addr_ff;
    assign msg_data_out        = msg_data_ff;
    assign primary_pending_out = primary_pending;

    // Read mux
    reg [31:0]  rd_mux;
    reg [127:0] rd_rec;

    always @* begin
        rd_mux = `RFE_ZERO32;
        rd_rec = rec_word[acc_slot[IDX_W-1:0]];
        if (acc_rec) begin
            rd_mux = rd_rec[acc_dw*32 +: 32];
        end else begin
            case (reg_addr_in)
                `RFE_OFF_STATUS: begin
                    rd_mux[`RFE_STS_FRI_LO +: IDX_W] = fri_ff;
                    rd_mux[`RFE_STS_PPF]             = primary_pending;
                    rd_mux[`RFE_STS_PFO]             = pfo_ff;
                end
                `RFE_OFF_CONTROL: begin
                    rd_mux[`RFE_CTL_IM] = im_ff;
                    rd_mux[`RFE_CTL_IP] = ip_ff;
                end
                `RFE_OFF_DATA:    rd_mux = data_ff;
                `RFE_OFF_ADDR_LO: rd_mux = {alo_ff, 2'h0};
                `RFE_OFF_ADDR_HI: rd_mux = ahi_ff;
                `RFE_OFF_ADV_LOG: rd_mux[`RFE_ADV_APF] = apf_ff;
                default:          rd_mux = `RFE_ZERO32;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n)
            reg_rdata_out <= `RFE_ZERO32;
        else if (reg_rd_in)
            reg_rdata_out <= rd_mux;
        else
            reg_rdata_out <= `RFE_ZERO32;
    end

endmodule // rfe_fault_event

/* File: dv/rfe_fault_event_checker.sv */
`timescale 1ns/1ps
`include "rfe_regs.vh"

module rfe_fault_event_checker (
    input wire                   mclk_in,
    input wire                   resetn_in,
    input wire [`RFE_ADDR_W-1:0] reg_addr_in,
    input wire                   reg_wr_in,
    input wire                   reg_rd_in,
    input wire [31:0]            reg_rdata_out,
    input wire                   adv_mode_in,
    input wire                   fault_in,
    input wire                   adv_rec_in,
    input wire                   primary_pending_out,
    input wire                   msg_valid_out,
    input wire [63:0]            msg_addr_out,
    input wire [31:0]            msg_data_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);

    // Fault taken while records are already pending, then quiet bus
    sequence s_busy_fault;
        fault_in && !adv_mode_in && primary_pending_out ##1 !reg_wr_in [*3];
    endsequence
    sequence s_free_fault;
        fault_in && !adv_mode_in && !primary_pending_out;
    endsequence

    a_pend_after_fault: assert property (s_free_fault |-> ##3 primary_pending_out)
        else $error("pending flag missing after fault");
    a_no_msg_busy: assert property (s_busy_fault |=> !msg_valid_out)
        else $error("message while faults pending");
    a_msg_pulse: assert property (msg_valid_out |=> !msg_valid_out)
        else $error("message longer than one cycle");
    a_msg_hold: assert property (!msg_valid_out |->
        $stable(msg_addr_out) && $stable(msg_data_out))
        else $error("message fields moved without a message");
    // Fault: fields, valid and pending, send; record or mask write: pending or mask, send
    a_msg_cause: assert property (msg_valid_out |->
        $past(fault_in, 3) || $past(adv_rec_in, 2) || $past(reg_wr_in, 2))
        else $error("message without cause");
    a_addr_low_zero: assert property (reg_rd_in &&
        reg_addr_in == `RFE_OFF_ADDR_LO |=> reg_rdata_out[1:0] == 2'h0)
        else $error("low address bits not zero");
    a_msg_align: assert property (msg_valid_out |-> msg_addr_out[1:0] == 2'h0)
        else $error("message address unaligned");
    a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data outside read cycle");
endmodule // rfe_fault_event_checker

bind rfe_fault_event rfe_fault_event_checker u_chk (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .adv_mode_in(adv_mode_in), .fault_in(fault_in), .adv_rec_in(adv_rec_in),
    .primary_pending_out(primary_pending_out), .msg_valid_out(msg_valid_out),
    .msg_addr_out(msg_addr_out), .msg_data_out(msg_data_out));

/* File: dv/rfe_msg_sink.sv */
`timescale 1ns/1ps

// Interrupt message receiver: counts writes and keeps the last one
module rfe_msg_sink (
    input  wire        mclk_in,
    input  wire        msg_valid_in,
    input  wire [63:0] msg_addr_in,
    input  wire [31:0] msg_data_in,
    output reg  [31:0] count_out,
    output reg  [63:0] last_addr_out,
    output reg  [31:0] last_data_out
);
    initial count_out = 32'h0;
    always @(posedge mclk_in) begin
        if (msg_valid_in === 1'b1) begin
            count_out     <= count_out + 32'h1;
            last_addr_out <= msg_addr_in;
            last_data_out <= msg_data_in;
        end
    end
endmodule // rfe_msg_sink

/* File: dv/rfe_fault_event_tb.sv */
`timescale 1ns/1ps

module rfe_fault_event_tb;
    reg         mclk_in = 1'b0;
    reg         resetn_in = 1'b0;
    reg         pwrgood_resetn_in = 1'b0;
    reg  [11:0] reg_addr_in = 12'h000;
    reg  [31:0] reg_wdata_in = 32'h0;
    reg         reg_wr_in = 1'b0;
    reg         reg_rd_in = 1'b0;
    reg         adv_mode_in = 1'b0;
    reg         fault_in = 1'b0;
    reg  [51:0] fault_page_in = 52'h0;
    reg  [15:0] fault_sid_in = 16'h0;
    reg  [7:0]  fault_reason_in = 8'h0;
    reg         fault_is_read_in = 1'b0;
    reg         adv_rec_in = 1'b0;
    reg         adv_rec_idx_zero_in = 1'b0;
    wire [31:0] reg_rdata_out;
    wire        primary_pending_out;
    wire        msg_valid_out;
    wire [63:0] msg_addr_out;
    wire [31:0] msg_data_out;
    wire [31:0] msg_count;
    wire [63:0] last_addr;
    wire [31:0] last_data;
    integer     failures = 0;
    integer     checks = 0;
    integer     cycles = 0;
    integer     seed = 32'hF3B21413;
    integer     m_cnt = 0;
    reg         m_ip = 1'b0;
    reg         m_im = 1'b1;
    reg         m_apf = 1'b0;
    reg  [1:0]  widx = 2'h0;
    reg  [3:0]  sv = 4'h0;
    reg  [15:0] ssid [0:3];
    reg  [15:0] rs;
    reg  [31:0] dreg;
    reg  [31:0] alo;
    reg  [31:0] ahi;

    rfe_fault_event uut (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .pwrgood_resetn_in(pwrgood_resetn_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .adv_mode_in(adv_mode_in), .fault_in(fault_in),
        .fault_page_in(fault_page_in), .fault_sid_in(fault_sid_in),
        .fault_reason_in(fault_reason_in), .fault_is_read_in(fault_is_read_in),
        .adv_rec_in(adv_rec_in), .adv_rec_idx_zero_in(adv_rec_idx_zero_in),
        .primary_pending_out(primary_pending_out), .msg_valid_out(msg_valid_out),
        .msg_addr_out(msg_addr_out), .msg_data_out(msg_data_out));
    rfe_msg_sink u_sink (.mclk_in(mclk_in), .msg_valid_in(msg_valid_out),
        .msg_addr_in(msg_addr_out), .msg_data_in(msg_data_out), .count_out(msg_count),
        .last_addr_out(last_addr), .last_data_out(last_data));

    always #2.5 mclk_in = ~mclk_in;

    always @(posedge mclk_in) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            report_and_stop;
        end
    end

    function [11:0] slot(input [1:0] k, input [1:0] dw);
        slot = {4'h1, 2'h0, k, dw, 2'h0};
    endfunction

    task report_and_stop;
        begin
            $display("checks=%0d failures=%0d", checks, failures);
            if (failures == 0 && checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    task chk(input [63:0] got, input [63:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task wr(input [11:0] a, input [31:0] d);
        begin
            @(posedge mclk_in);
            reg_addr_in  <= a;
            reg_wdata_in <= d;
            reg_wr_in    <= 1'b1;
            @(posedge mclk_in);
            reg_wr_in    <= 1'b0;
        end
    endtask

    task rd(input [11:0] a, input [31:0] e);
        begin
            @(posedge mclk_in);
            reg_addr_in <= a;
            reg_rd_in   <= 1'b1;
            @(posedge mclk_in);
            reg_rd_in   <= 1'b0;
            #1 chk({32'h0, reg_rdata_out}, {32'h0, e});
        end
    endtask

    // Model: a pending interrupt leaves only with the mask clear
    task send;
        if (m_ip && !m_im) begin
            m_ip  = 1'b0;
            m_cnt = m_cnt + 1;
        end
    endtask

    task settle;
        begin
            repeat (6) @(posedge mclk_in);
            chk({32'h0, msg_count}, m_cnt);
            if (m_cnt > 0) begin
                chk(last_addr, {ahi, alo});
                chk({32'h0, last_data}, {32'h0, dreg});
            end
            rd(12'h038, {m_im, m_ip, 30'h0});
        end
    endtask

    task cfg;
        begin
            dreg = $random(seed);
            alo  = $random(seed);
            ahi  = $random(seed);
            wr(12'h03C, dreg);
            wr(12'h040, alo);
            wr(12'h044, ahi);
            alo[1:0] = 2'h0;
            rd(12'h03C, dreg);
            rd(12'h040, alo);
            rd(12'h044, ahi);
            rd(12'h010, 32'h0);
            wr(12'h038, 32'hC000_0000);
            rd(12'h038, 32'h8000_0000);
        end
    endtask

    task flt(input [15:0] s, input r);
        reg [51:0] p;
        reg        hit;
        integer    i;
        begin
            p   = {16'h0000, $random(seed), 4'h5};
            hit = 1'b0;
            for (i = 0; i < 4; i = i + 1)
                if (sv[i] && ssid[i] === s) hit = 1'b1;
            @(posedge mclk_in);
            fault_in         <= 1'b1;
            fault_sid_in     <= s;
            fault_page_in    <= p;
            fault_reason_in  <= p[11:4];
            fault_is_read_in <= r;
            @(posedge mclk_in);
            fault_in         <= 1'b0;
            repeat (4) @(posedge mclk_in);
            if (!hit) begin
                if (sv == 4'h0) m_ip = 1'b1;
                sv[widx]   = 1'b1;
                ssid[widx] = s;
                rd(slot(widx, 2'h3), {1'b1, r, 22'h0, p[11:4]});
                rd(slot(widx, 2'h2), {16'h0, s});
                rd(slot(widx, 2'h0), {p[19:0], 12'h000});
                rd(slot(widx, 2'h1), p[51:20]);
                widx = widx + 2'h1;
            end
            send;
        end
    endtask

    task setim(input v);
        begin
            wr(12'h038, {v, 31'h0});
            m_im = v;
            send;
        end
    endtask

    task clr(input [1:0] k);
        begin
            wr(slot(k, 2'h3), 32'h8000_0000);
            sv[k] = 1'b0;
            if (sv == 4'h0) m_ip = 1'b0;
        end
    endtask

    task clrapf;
        begin
            wr(12'h058, 32'h0000_0002);
            if (m_apf) m_ip = 1'b0;
            m_apf = 1'b0;
        end
    endtask

    task arec(input z);
        begin
            @(posedge mclk_in);
            adv_rec_in          <= 1'b1;
            adv_rec_idx_zero_in <= z;
            @(posedge mclk_in);
            adv_rec_in          <= 1'b0;
            if (z && !m_apf) begin
                m_apf = 1'b1;
                m_ip  = 1'b1;
            end
            send;
        end
    endtask

    initial begin
        repeat (5) @(posedge mclk_in);
        resetn_in         <= 1'b1;
        pwrgood_resetn_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        cfg;
        flt(16'hA5A1, 1'b1);
        settle;
        flt(16'h3C02, 1'b0);
        flt(16'hA5A1, 1'b0);
        rd(slot(2'h2, 2'h3), 32'h0);
        settle;
        setim(1'b0);
        settle;
        @(posedge mclk_in);
        resetn_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        m_im = 1'b1;
        m_ip = 1'b0;
        widx = 2'h0;
        chk({63'h0, primary_pending_out}, 64'h1);
        cfg;
        clr(2'h0);
        clr(2'h1);
        #1 chk({63'h0, primary_pending_out}, 64'h0);
        setim(1'b0);
        rs = $random(seed);
        flt(rs, 1'b0);
        settle;
        clr(2'h0);
        setim(1'b1);
        flt(rs, 1'b1);
        settle;
        clr(2'h1);
        settle;
        setim(1'b0);
        settle;
        @(posedge mclk_in);
        adv_mode_in <= 1'b1;
        setim(1'b1);
        arec(1'b1);
        settle;
        clrapf;
        setim(1'b0);
        settle;
        arec(1'b0);
        settle;
        arec(1'b1);
        arec(1'b1);
        settle;
        setim(1'b1);
        clrapf;
        arec(1'b1);
        setim(1'b0);
        settle;
        report_and_stop;
    end
endmodule // rfe_fault_event_tb
